// [rtl/lcae_engine.sv]
// Register-controlled cipher engine for link authentication
// Summary of operation
// - Status bit 10 flags random done.
// - Random value readable in high/low registers.
// - Key status bit 0 flags vector ready.
// - Local vector readable high and low.
// - Bit 2 pulse aborts master key computation.
// - Key status bit 1 flags key ready.
// - Bit 16 clear selects key; bit 8 starts.
// - Cipher status bit 8 flags block done.
// - Link check value low word readable after block cipher.
`timescale 1ns/1ps
`include "lcae_defines.svh"
module lcae_engine
  import lcae_pkg::*;
#(
  parameter logic [39:0] LOCAL_KSV = 40'h55_aa55_aa55, // Arbitrary value
  parameter logic [31:0] VERSION   = 32'h0001_0000     // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             core_enable,
  output logic      [2:0]  lane_count,
  output logic      [63:0] link_check_value
);

  // ****************************************
  // Register decode
  // ****************************************
  logic wr_ctl, wr_kmc, wr_rksv_l, wr_rksv_h, wr_cic;
  logic wr_bx, wr_by, wr_bz, wr_kx, wr_ky, wr_kz;
  assign wr_ctl    = wr && (addr == `LCAE_OFS_CONTROL);
  assign wr_kmc    = wr && (addr == `LCAE_OFS_KM_CTRL);
  assign wr_rksv_l = wr && (addr == `LCAE_OFS_REMOTE_KSV_L);
  assign wr_rksv_h = wr && (addr == `LCAE_OFS_REMOTE_KSV_H);
  assign wr_cic    = wr && (addr == `LCAE_OFS_CI_CTRL);
  assign wr_bx     = wr && (addr == `LCAE_OFS_BX);
  assign wr_by     = wr && (addr == `LCAE_OFS_BY);
  assign wr_bz     = wr && (addr == `LCAE_OFS_BZ);
  assign wr_kx     = wr && (addr == `LCAE_OFS_KX);
  assign wr_ky     = wr && (addr == `LCAE_OFS_KY);
  assign wr_kz     = wr && (addr == `LCAE_OFS_KZ);

  // ****************************************
  // Software registers
  // ****************************************
  logic [31:0] control;          // Enable, update, lanes
  logic [31:0] ci_ctrl;          // Cipher control, level bits kept
  logic [2:0]  km_ctrl;          // Key management control echo
  logic [39:0] remote_ksv;       // Peer vector
  logic [31:0] cipher_b_word_x;  // B words
  logic [31:0] cipher_b_word_y;
  logic [31:0] cipher_b_word_z;
  logic [31:0] cipher_k_word_x;  // K words
  logic [31:0] cipher_k_word_y;
  logic [31:0] cipher_k_word_z;

  // Rising edges of start bits form the one-write pulses
  logic start_rand, start_block, start_load, start_km, abort_km;
  assign start_rand  = wr_cic && wdata[`LCAE_CIC_RAND_GO] && !ci_ctrl[`LCAE_CIC_RAND_GO];
  assign start_block = wr_cic && wdata[`LCAE_CIC_BLOCK_GO] && !ci_ctrl[`LCAE_CIC_BLOCK_GO];
  assign start_load  = wr_kmc && wdata[`LCAE_KMC_LOAD_KSV] && !km_ctrl[`LCAE_KMC_LOAD_KSV];
  assign start_km    = wr_kmc && wdata[`LCAE_KMC_CALC_KM] && !km_ctrl[`LCAE_KMC_CALC_KM];
  assign abort_km    = wr_kmc && wdata[`LCAE_KMC_ABORT_KM] && !km_ctrl[`LCAE_KMC_ABORT_KM];

  // Control and command registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      control <= `LCAE_RST_CONTROL;
      ci_ctrl <= '0;
      km_ctrl <= '0;
    end else begin
      if (wr_ctl) begin
        control <= wdata;
      end
      if (wr_cic) begin
        ci_ctrl <= wdata;
      end
      if (wr_kmc) begin
        km_ctrl <= wdata[2:0];
      end
    end
  end

  // Data registers written by software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remote_ksv      <= '0;
      cipher_b_word_x <= '0;
      cipher_b_word_y <= '0;
      cipher_b_word_z <= '0;
      cipher_k_word_x <= '0;
      cipher_k_word_y <= '0;
      cipher_k_word_z <= '0;
    end else begin
      if (wr_rksv_l) remote_ksv[31:0]  <= wdata;
      if (wr_rksv_h) remote_ksv[39:32] <= wdata[7:0];
      if (wr_bx) cipher_b_word_x <= wdata;
      if (wr_by) cipher_b_word_y <= wdata;
      if (wr_bz) cipher_b_word_z <= wdata;
      if (wr_kx) cipher_k_word_x <= wdata;
      if (wr_ky) cipher_k_word_y <= wdata;
      if (wr_kz) cipher_k_word_z <= wdata;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  lcae_state_type state, next_state;
  logic [5:0]     rounds;           // Rounds left in current job
  logic [63:0]    core_state;
  logic [63:0]    master_key;
  logic [63:0]    session_random_value;
  logic [39:0]    local_ksv;
  logic           ksv_ready, km_ready, rand_done, block_done;
  logic           enabled;
  assign enabled = control[`LCAE_CTL_ENABLE];

  // Seed and key for the round core per job
  logic        core_load, core_step;
  logic [63:0] core_seed, core_key, block_key;
  assign block_key = ci_ctrl[`LCAE_CIC_KEY_SRC]
                   ? {cipher_k_word_y, cipher_k_word_x ^ cipher_k_word_z} : master_key;
  assign core_load = enabled && (start_rand || start_km || start_block) && (state == LCAE_IDLE);
  assign core_step = (state != LCAE_IDLE) && (rounds != 6'd0);
  assign core_seed = start_rand ? session_random_value ^ `LCAE_RST_LFSR
                   : start_km   ? {24'h00_0000, local_ksv ^ remote_ksv}
                   : {cipher_b_word_z ^ cipher_b_word_y, cipher_b_word_x};
  assign core_key  = (state == LCAE_BLOCK) ? block_key
                   : (state == LCAE_KM) ? {24'h00_0000, remote_ksv} : 64'h9e37_79b9_7f4a_7c15;

  lcae_round #(
    .WIDTH (64)
  ) u_round (
    .clk    (clk),
    .arst_n (arst_n),
    .load   (core_load),
    .step   (core_step),
    .seed   (core_seed),
    .key    (core_key),
    .xor_en (ci_ctrl[`LCAE_CIC_XOR_EN]),
    .state  (core_state)
  );

  // Next state; starts are taken only when idle
  always_comb begin
    next_state = state;
    unique case (state)
      LCAE_IDLE: begin
        if (core_load && start_rand) next_state = LCAE_RAND;
        else if (core_load && start_km) next_state = LCAE_KM;
        else if (core_load) next_state = LCAE_BLOCK;
      end
      LCAE_KM: begin
        if (abort_km || rounds == 6'd0) next_state = LCAE_IDLE;
      end
      LCAE_RAND, LCAE_BLOCK: begin
        if (rounds == 6'd0) next_state = LCAE_IDLE;
      end
    endcase
  end

  // Round counter and state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= LCAE_IDLE;
      rounds <= '0;
    end else begin
      state <= next_state;
      if (core_load) begin
        rounds <= start_rand ? `LCAE_RAND_ROUNDS : start_km ? `LCAE_KM_ROUNDS : `LCAE_BLOCK_ROUNDS;
      end else if (core_step) begin
        rounds <= rounds - 6'd1;
      end
    end
  end

  // ****************************************
  // Results and sticky done flags
  // ****************************************
  logic finish;
  assign finish = (state != LCAE_IDLE) && (rounds == 6'd0);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ksv_ready            <= 1'b0;
      km_ready             <= 1'b0;
      rand_done            <= 1'b0;
      block_done           <= 1'b0;
      local_ksv            <= '0;
      master_key           <= '0;
      session_random_value <= '0;
      link_check_value     <= '0;
    end else begin
      if (start_load && enabled) begin
        local_ksv <= LOCAL_KSV;
        ksv_ready <= 1'b1;
      end
      // key ready on finish, cleared by start
      if (start_km && core_load) km_ready <= 1'b0;
      else if (finish && state == LCAE_KM && !abort_km) begin
        km_ready   <= 1'b1;
        master_key <= core_state;
      end
      if (start_rand && core_load) rand_done <= 1'b0;
      else if (finish && state == LCAE_RAND) begin
        rand_done            <= 1'b1;
        session_random_value <= core_state;
      end
      if (start_block && core_load && !start_rand) block_done <= 1'b0;
      else if (finish && state == LCAE_BLOCK) begin
        block_done       <= 1'b1;
        link_check_value <= core_state;
      end
    end
  end

  // Outputs registered from control register bits while update bit is set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_enable <= 1'b0;
      lane_count  <= '0;
    end else if (control[`LCAE_CTL_UPDATE]) begin
      // Held while update bit is low so multi-word writes land together
      core_enable <= enabled;
      lane_count  <= control[`LCAE_CTL_LANES_LSB+2:`LCAE_CTL_LANES_LSB];
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (addr)
      `LCAE_OFS_CONTROL:      next_rdata = control;
      `LCAE_OFS_VERSION:      next_rdata = VERSION;
      `LCAE_OFS_KM_CTRL:      next_rdata = {29'h0, km_ctrl};
      `LCAE_OFS_KM_STATUS:    next_rdata = {29'h0, state == LCAE_KM, km_ready, ksv_ready};
      `LCAE_OFS_LOCAL_KSV_L:  next_rdata = local_ksv[31:0];
      `LCAE_OFS_LOCAL_KSV_H:  next_rdata = {24'h0, local_ksv[39:32]};
      `LCAE_OFS_REMOTE_KSV_L: next_rdata = remote_ksv[31:0];
      `LCAE_OFS_REMOTE_KSV_H: next_rdata = {24'h0, remote_ksv[39:32]};
      `LCAE_OFS_MKEY_L:       next_rdata = master_key[31:0];
      `LCAE_OFS_MKEY_H:       next_rdata = master_key[63:32];
      `LCAE_OFS_CI_CTRL:      next_rdata = ci_ctrl;
      `LCAE_OFS_CI_STATUS:    next_rdata = {21'h0, rand_done, 1'b0, block_done, 8'h0};
      `LCAE_OFS_BX:           next_rdata = cipher_b_word_x;
      `LCAE_OFS_BY:           next_rdata = cipher_b_word_y;
      `LCAE_OFS_BZ:           next_rdata = cipher_b_word_z;
      `LCAE_OFS_KX:           next_rdata = cipher_k_word_x;
      `LCAE_OFS_KY:           next_rdata = cipher_k_word_y;
      `LCAE_OFS_KZ:           next_rdata = cipher_k_word_z;
      `LCAE_OFS_RAND_L:       next_rdata = session_random_value[31:0];
      `LCAE_OFS_RAND_H:       next_rdata = session_random_value[63:32];
      `LCAE_OFS_LINK_CHECK:   next_rdata = link_check_value[31:0];
      default:                next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? next_rdata : 32'h0000_0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_RAND_DONE: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LCAE_RAND && rounds == 6'd0) |=> rand_done)
    else $error("random done flag not set");
  AST_RAND_VALUE: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LCAE_RAND && rounds == 6'd0) |=> session_random_value == $past(core_state))
    else $error("session value not captured");
  AST_KSV_READY: assert property (@(posedge clk) disable iff (!arst_n)
    (start_load && enabled) |=> ksv_ready)
    else $error("vector ready not set");
  AST_KSV_READ: assert property (@(posedge clk) disable iff (!arst_n)
    (start_load && enabled) |=> local_ksv == LOCAL_KSV)
    else $error("local vector wrong");
  AST_ABORT: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LCAE_KM && abort_km) |=> (state == LCAE_IDLE) && !km_ready)
    else $error("abort ignored");
  AST_KM_TIME: assert property (@(posedge clk) disable iff (!arst_n)
    (core_load && start_km) |=> (!km_ready throughout ##40 1'b1))
    else $error("key ready early");
  AST_BLOCK_DONE: assert property (@(posedge clk) disable iff (!arst_n)
    (core_load && start_block && !start_rand) |-> ##50 block_done)
    else $error("block cipher late");
  AST_LINK_CHECK: assert property (@(posedge clk) disable iff (!arst_n)
    (state == LCAE_BLOCK && rounds == 6'd0) |=> link_check_value == $past(core_state))
    else $error("link check not captured");
  AST_STICKY: assert property (@(posedge clk) disable iff (!arst_n)
    (block_done && !(start_block && core_load)) |=> block_done)
    else $error("done flag dropped");

endmodule : lcae_engine

// [rtl/lcae_defines.svh]
// Register offsets, field positions, reset values and timing counts of the link cipher engine
`ifndef LCAE_DEFINES_SVH
`define LCAE_DEFINES_SVH

// ****************************************
// Register word offsets (byte addresses)
// ****************************************
`define LCAE_OFS_CONTROL      8'h00
`define LCAE_OFS_VERSION      8'h04
`define LCAE_OFS_KM_CTRL      8'h08
`define LCAE_OFS_KM_STATUS    8'h0c
`define LCAE_OFS_LOCAL_KSV_L  8'h10
`define LCAE_OFS_LOCAL_KSV_H  8'h14
`define LCAE_OFS_REMOTE_KSV_L 8'h18
`define LCAE_OFS_REMOTE_KSV_H 8'h1c
`define LCAE_OFS_MKEY_L       8'h20
`define LCAE_OFS_MKEY_H       8'h24
`define LCAE_OFS_CI_CTRL      8'h28
`define LCAE_OFS_CI_STATUS    8'h2c
`define LCAE_OFS_BX           8'h30
`define LCAE_OFS_BY           8'h34
`define LCAE_OFS_BZ           8'h38
`define LCAE_OFS_KX           8'h3c
`define LCAE_OFS_KY           8'h40
`define LCAE_OFS_KZ           8'h44
`define LCAE_OFS_RAND_L       8'h48
`define LCAE_OFS_RAND_H       8'h4c
`define LCAE_OFS_LINK_CHECK   8'h50

// ****************************************
// Field positions
// ****************************************
`define LCAE_CTL_ENABLE       0
`define LCAE_CTL_UPDATE       1
`define LCAE_CTL_LANES_LSB    4
`define LCAE_KMC_LOAD_KSV     0
`define LCAE_KMC_CALC_KM      1
`define LCAE_KMC_ABORT_KM     2
`define LCAE_KMS_KSV_READY    0
`define LCAE_KMS_KM_READY     1
`define LCAE_KMS_KM_BUSY      2
`define LCAE_CIC_XOR_EN       0
`define LCAE_CIC_BLOCK_GO     8
`define LCAE_CIC_RAND_GO      10
`define LCAE_CIC_KEY_SRC      16
`define LCAE_CIS_BLOCK_DONE   8
`define LCAE_CIS_RAND_DONE    10

// ****************************************
// Reset values and timing counts
// ****************************************
`define LCAE_RST_CONTROL      32'h0000_0000
`define LCAE_RST_LFSR         64'h0123_4567_89ab_cdef
`define LCAE_KM_ROUNDS        6'd40
`define LCAE_BLOCK_ROUNDS     6'd48
`define LCAE_RAND_ROUNDS      6'd32

`endif

// [rtl/lcae_pkg.sv]
// Types shared by the link cipher engine files
package lcae_pkg;

  // One-hot state of the round sequencer
  typedef enum logic [3:0] {
    LCAE_IDLE  = 4'b0001,
    LCAE_RAND  = 4'b0010,
    LCAE_KM    = 4'b0100,
    LCAE_BLOCK = 4'b1000
  } lcae_state_type;

  // Job selector type; not used by the engine or the round core
  typedef enum logic [1:0] {
    LCAE_JOB_RAND  = 2'b00,
    LCAE_JOB_KM    = 2'b01,
    LCAE_JOB_BLOCK = 2'b10
  } lcae_job_type;

endpackage : lcae_pkg

// [rtl/lcae_round.sv]
// Iterated mixing round shared by random, master key and block cipher jobs
`timescale 1ns/1ps
module lcae_round
  import lcae_pkg::*;
#(
  parameter int WIDTH = 64
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic             step,
  input  wire logic [WIDTH-1:0] seed,
  input  wire logic [WIDTH-1:0] key,
  input  wire logic             xor_en,
  output logic      [WIDTH-1:0] state
);

  // ****************************************
  // Mixing function
  // ****************************************
  // Rotate, add key, fold; not a real cipher, only a stand-in datapath
  function automatic logic [WIDTH-1:0] lcae_mix(input logic [WIDTH-1:0] s, input logic [WIDTH-1:0] k,
                                                input logic x);
    logic [WIDTH-1:0] r;
    r = {s[WIDTH-14:0], s[WIDTH-1:WIDTH-13]};
    r = r + k;
    lcae_mix = x ? (r ^ (s >> 7)) : (r ^ {s[0], s[WIDTH-1:1]});
  endfunction : lcae_mix

  // Next round value
  logic [WIDTH-1:0] next_state;
  assign next_state = load ? seed : lcae_mix(state, key, xor_en);

  // State register, moves only when asked
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else if (load || step) begin
      state <= next_state;
    end
  end

endmodule : lcae_round

// [bench/lcae_engine_tb.sv]
// Self-checking bench for the link cipher engine
`timescale 1ns/1ps
`include "lcae_defines.svh"
module lcae_engine_tb;
  import lcae_pkg::*;
  // ****************************************
  // Constants, signals and bookkeeping
  // ****************************************
  localparam logic [39:0] KSV_VAL = 40'h3c_5a69_a596; // Arbitrary value
  localparam logic [31:0] VER_VAL = 32'h0002_0300;    // Arbitrary value
  localparam logic [7:0]  CTL     = `LCAE_OFS_CONTROL;
  localparam logic [7:0]  KMC     = `LCAE_OFS_KM_CTRL;
  localparam logic [7:0]  KMS     = `LCAE_OFS_KM_STATUS;
  localparam logic [7:0]  CIC     = `LCAE_OFS_CI_CTRL;
  localparam logic [7:0]  CIS     = `LCAE_OFS_CI_STATUS;
  localparam logic [31:0] ALL     = 32'hffff_ffff;
  typedef struct {
    string       name;
    logic [31:0] exp;
    logic [31:0] mask;
  } lcae_note_type;
  logic          clk;              // Core clock
  logic          arst_n;           // Reset, active low
  logic [7:0]    addr;             // Register byte address
  logic [31:0]   wdata;            // Write data
  logic          wr;               // Write strobe
  logic          rd;               // Read strobe
  logic [31:0]   rdata;            // Read data
  logic          core_enable;      // Enable output
  logic [2:0]     lane_count;      // Lane count output
  logic [63:0]   link_check_value; // Link check output
  logic          rd_seen;          // Read taken at last edge
  logic [31:0]   last_rd;          // Last read data
  logic [31:0]   ctl_val;          // Control word in use
  logic [31:0]   rnd_lo;           // Random low word seen
  logic [31:0]   rnd_hi;           // Random high word seen
  logic [31:0]   mk_lo;            // Master key low word seen
  logic [31:0]   mk_hi;            // Master key high word seen
  logic [31:0]   cic_val;          // Cipher control base per pass
  lcae_note_type notes[$];         // Expected read results
  lcae_note_type cur;              // Note under comparison
  int            n_fail;           // Mismatches
  int            samples_checked;  // Comparisons made

  lcae_engine #(
    .LOCAL_KSV (KSV_VAL),
    .VERSION   (VER_VAL)
  ) u_dut (
    .clk              (clk),
    .arst_n           (arst_n),
    .addr             (addr),
    .wdata            (wdata),
    .wr               (wr),
    .rd               (rd),
    .rdata            (rdata),
    .core_enable      (core_enable),
    .lane_count       (lane_count),
    .link_check_value (link_check_value)
  );

  // ****************************************
  // Clock, comparison and bus tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cmp_rd(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_rd

  task automatic cmp_out(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : cmp_out

  // One-cycle write; strobe dropped at the taking edge
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_write

  // One-cycle read; the note goes in before the strobe
  task automatic bus_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string n);
    notes.push_back('{n, e, m});
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    last_rd = rdata;
  endtask : bus_read

  // Start commands need a 0 to 1 edge, so set then clear
  task automatic pulse(input logic [7:0] a, input int b, input logic [31:0] base);
    bus_write(a, base | (32'h1 << b));
    bus_write(a, base);
  endtask : pulse

  // Bounded poll, then one counted check of the bit
  task automatic poll(input logic [7:0] a, input int b, input string n);
    int k;
    k = 0;
    last_rd = 32'h0;
    while (last_rd[b] !== 1'b1 && k < 60) begin
      bus_read(a, 32'h0, 32'h0, n);
      k++;
    end
    bus_read(a, 32'h1 << b, 32'h1 << b, n);
  endtask : poll

  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // ****************************************
  // Result monitor and watchdog
  // ****************************************
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_seen <= rd;
  end

  always @(negedge clk) begin
    if (rd_seen && notes.size() > 0) begin
      cur = notes.pop_front();
      // Mask zero marks an unchecked read, such as a poll or a value capture
      if (cur.mask != 32'h0) begin
        cmp_rd(cur.name, cur.exp & cur.mask, rdata & cur.mask);
      end
    end else if (!rd_seen) begin
      // Read data must sit at zero outside the answering cycle
      cmp_rd("rdata_idle", 32'h0, rdata);
    end
  end

  // Whole run needs under 3000 cycles
  initial begin
    #(25 * 20000);
    n_fail++;
    final_report();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    n_fail = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    void'($urandom(32'hd2b9));
    ctl_val = {25'h0, 3'($urandom_range(1, 4)), 4'h3};
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values and read-only version
    bus_read(CIS, 32'h0, ALL, "ci_status_rst");
    bus_read(KMS, 32'h0, ALL, "km_status_rst");
    bus_write(`LCAE_OFS_VERSION, $urandom);
    bus_read(`LCAE_OFS_VERSION, VER_VAL, ALL, "version_ro");
    pulse(CIC, `LCAE_CIC_RAND_GO, 32'h0);
    repeat (50) @(posedge clk);
    bus_read(CIS, 32'h0, 32'h400, "rand_disabled");
    bus_write(CTL, ctl_val & ~32'h2);
    repeat (3) @(posedge clk);
    cmp_out("ctl_gated", 32'h0, {28'h0, core_enable, lane_count});
    bus_write(CTL, ctl_val);
    repeat (3) @(posedge clk);
    cmp_out("ctl_applied", {28'h1, ctl_val[6:4]}, {28'h0, core_enable, lane_count});
    bus_write(CIC, 32'h0);
    pulse(CIC, `LCAE_CIC_RAND_GO, 32'h0);
    bus_read(CIS, 32'h0, 32'h400, "rand_early");
    poll(CIS, `LCAE_CIC_RAND_GO, "rand_done");
    bus_read(`LCAE_OFS_RAND_L, 32'h0, 32'h0, "rand_lo");
    rnd_lo = last_rd;
    bus_read(`LCAE_OFS_RAND_H, 32'h0, 32'h0, "rand_hi");
    rnd_hi = last_rd;
    pulse(KMC, `LCAE_KMC_LOAD_KSV, 32'h0);
    bus_read(KMS, 32'h1, 32'h1, "ksv_ready");
    bus_read(`LCAE_OFS_LOCAL_KSV_H, {24'h0, KSV_VAL[39:32]}, 32'hff, "ksv_hi");
    bus_read(`LCAE_OFS_LOCAL_KSV_L, KSV_VAL[31:0], ALL, "ksv_lo");
    // peer vector, bracketed by update bit
    bus_write(CTL, ctl_val & ~32'h2);
    bus_write(`LCAE_OFS_REMOTE_KSV_H, $urandom & 32'hff);
    bus_write(`LCAE_OFS_REMOTE_KSV_L, $urandom);
    bus_write(CTL, ctl_val);
    pulse(KMC, `LCAE_KMC_CALC_KM, 32'h0);
    bus_read(KMS, 32'h4, 32'h6, "km_busy");
    pulse(KMC, `LCAE_KMC_ABORT_KM, 32'h0);
    bus_read(KMS, 32'h0, 32'h6, "km_aborted");
    repeat (60) @(posedge clk);
    bus_read(KMS, 32'h0, 32'h6, "km_stays_off");
    pulse(KMC, `LCAE_KMC_CALC_KM, 32'h0);
    poll(KMS, `LCAE_KMS_KM_READY, "km_ready");
    bus_read(KMS, 32'h3, 32'h7, "km_idle");
    bus_read(`LCAE_OFS_MKEY_L, 32'h0, 32'h0, "mkey_lo");
    mk_lo = last_rd;
    bus_read(`LCAE_OFS_MKEY_H, 32'h0, 32'h0, "mkey_hi");
    mk_hi = last_rd;
    bus_write(CTL, ctl_val & ~32'h2);
    bus_write(`LCAE_OFS_BX, rnd_lo);
    bus_write(`LCAE_OFS_BY, rnd_hi);
    bus_write(`LCAE_OFS_BZ, 32'h0);
    bus_write(`LCAE_OFS_KX, mk_lo);
    bus_write(`LCAE_OFS_KY, mk_hi);
    bus_write(`LCAE_OFS_KZ, 32'h0);
    bus_write(CTL, ctl_val);
    // computed key, block start, both flavours
    // Third pass takes the key from the K words
    for (int f = 0; f < 3; f++) begin
      cic_val = (f == 2) ? 32'h0001_0001 : 32'(f);
      bus_write(CIC, cic_val);
      pulse(CIC, `LCAE_CIC_BLOCK_GO, cic_val);
      bus_read(CIS, 32'h400, 32'h500, "block_early");
      poll(CIS, `LCAE_CIS_BLOCK_DONE, "block_done");
      bus_read(`LCAE_OFS_LINK_CHECK, 32'h0, 32'h0, "link_check");
      cmp_out("link_check_reg", link_check_value[31:0], last_rd);
    end
    bus_read(`LCAE_OFS_RAND_L, rnd_lo, ALL, "rand_held");
    bus_read(`LCAE_OFS_RAND_H, rnd_hi, ALL, "rand_held_hi");
    // Unmapped place reads zero, flags untouched
    addr <= 8'h00;
    bus_write(8'(8'h54 + 4 * $urandom_range(0, 42)), $urandom);
    bus_read(8'(8'h54 + 4 * $urandom_range(0, 42)), 32'h0, ALL, "unmapped");
    bus_read(CIS, 32'h500, 32'h500, "flags_sticky");
    repeat (4) @(posedge clk);
    final_report();
  end

endmodule : lcae_engine_tb
